// File: cig_core.v
// Interrupt acceptance, masking and flag handling for a processor core.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "cig_regs.vh"
module cig_core (
  input wire clk,
  input wire rst,
  input wire nmiPin,
  input wire intrPin,
  input wire [7:0] intrVector,
  input wire busNmiMsg,
  input wire apicValid,
  input wire apicNmi,
  input wire [7:0] apicVector,
  input wire boundary,
  input wire retireValid,
  input wire [3:0] retireOp,
  input wire [31:0] flagImage,
  input wire [1:0] current_privilege_level,
  input wire [1:0] io_privilege_threshold,
  input wire v86Mode,
  input wire gateIsTrap,
  input wire excValid,
  input wire [7:0] excVector,
  input wire excHasErrCode,
  input wire bpMatch,
  input wire stepTrap,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg dispatchValid,
  output reg [7:0] dispatchVector,
  output reg [2:0] dispatchKind,
  output reg pushErrorCode,
  output reg intrAck,
  output reg excTaken,
  output reg gpFault,
  output reg pushValid,
  output reg [31:0] pushData,
  output reg ifFlag,
  output reg resumeFlag,
  output reg nmiBlocked,
  output reg apicReady
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wire nmiPinSync;
  wire intrPinSync;
  wire [7:0] intrVectorSync;
  wire [31:0] ctrlReg;
  wire apicEnable;
  reg nmiPinLast_reg;
  reg nmiPend_reg;
  reg nmiPend_next;
  reg apicPend_reg;
  reg apicPend_next;
  reg [7:0] apicVec_reg;
  reg [7:0] apicVec_next;
  reg shadow_reg;
  reg shadow_next;
  reg [31:0] flags_reg;
  reg [31:0] flags_next;
  reg nmiBlocked_next;
  reg gpFault_next;
  reg [2:0] kind_next;
  reg [7:0] vector_next;
  reg errCode_next;
  reg [10:0] last_reg;
  wire nmiEvent;
  wire apicMaskEvent;
  wire debugOk;
  wire nmiOk;
  wire maskOk;
  wire codeBpOk;
  wire privOk;
  wire retFaults;
  wire taking;
  wire [31:0] statusWord;

  // Tells whether a privilege level may touch the interrupt flag.
  function privAllows;
    input [1:0] level;
    input [1:0] threshold;
    begin
      privAllows = (level <= threshold);
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisation and source detection
  // ----------------------------------------------------------------
  cig_sync #(.WIDTH(1)) uNmiSync (
    .clk(clk),
    .rst(rst),
    .async(nmiPin),
    .synced(nmiPinSync)
  );

  cig_sync #(.WIDTH(1)) uIntrSync (
    .clk(clk),
    .rst(rst),
    .async(intrPin),
    .synced(intrPinSync)
  );

  // The vector is held stable by the source while its request stands.
  cig_sync #(.WIDTH(8)) uVecSync (
    .clk(clk),
    .rst(rst),
    .async(intrVector),
    .synced(intrVectorSync)
  );

  // Edge memory for the nonmaskable pin after synchronisation.
  always @(posedge clk) begin
    if (rst) begin
      nmiPinLast_reg <= 1'b0;
    end else begin
      nmiPinLast_reg <= nmiPinSync;
    end
  end

  assign apicEnable = ctrlReg[`CIG_CTRL_LOCAL_INTERRUPT_CONTROLLER_EN];
  // A pin edge, a bus message or a nonmaskable message from the enabled controller marks a true nonmaskable.
  assign nmiEvent = (nmiPinSync & ~nmiPinLast_reg) | busNmiMsg |
                    (apicValid & apicNmi & apicEnable);
  assign apicMaskEvent = apicValid & ~apicNmi & apicEnable & ~apicPend_reg;

  // ----------------------------------------------------------------
  // Boundary arbitration
  // ----------------------------------------------------------------
  // The shadow after a stack-segment load holds off every interrupt and debug event.
  assign debugOk = stepTrap & ~shadow_reg;
  // The interrupt flag is not consulted for nonmaskable requests.
  assign nmiOk = nmiPend_reg & ~nmiBlocked & ~shadow_reg;
  // Maskable sources only form a request while the flag is set.
  assign maskOk = ifFlag & ~shadow_reg & (apicPend_reg | intrPinSync);
  // A breakpoint match is dropped while the resume flag is set.
  assign codeBpOk = bpMatch & ~flags_reg[`CIG_FLAG_RF] & ~shadow_reg;
  assign taking = boundary & (debugOk | nmiOk | maskOk | codeBpOk | excValid);

  // Picks the highest class and its vector; lower ones are left as they are.
  always @* begin
    kind_next = `CIG_KIND_NONE;
    vector_next = 8'h00;
    errCode_next = 1'b0;
    if (boundary) begin
      if (debugOk) begin
        kind_next = `CIG_KIND_DEBUG;
        vector_next = `CIG_VEC_DEBUG;
      end else if (nmiOk) begin
        kind_next = `CIG_KIND_NMI;
        vector_next = `CIG_VEC_NMI;
      end else if (maskOk && apicPend_reg) begin
        kind_next = `CIG_KIND_LOCAL_INTERRUPT_CONTROLLER;
        vector_next = apicVec_reg;
      end else if (maskOk) begin
        // A pin vector of two is still an ordinary maskable interrupt.
        kind_next = `CIG_KIND_PIN;
        vector_next = intrVectorSync;
        errCode_next = 1'b0;
      end else if (codeBpOk) begin
        kind_next = `CIG_KIND_DEBUG;
        vector_next = `CIG_VEC_DEBUG;
      end else if (excValid) begin
        // Core exceptions pass whatever the interrupt flag says.
        kind_next = `CIG_KIND_EXC;
        vector_next = excVector;
        errCode_next = excHasErrCode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pending request latches
  // ----------------------------------------------------------------
  // A new nonmaskable event in the cycle it is consumed keeps that request pending.
  always @* begin
    nmiPend_next = nmiEvent | (nmiPend_reg & ~(kind_next == `CIG_KIND_NMI));
    apicPend_next = apicPend_reg;
    apicVec_next = apicVec_reg;
    if (kind_next == `CIG_KIND_LOCAL_INTERRUPT_CONTROLLER) begin
      apicPend_next = 1'b0;
    end
    if (apicMaskEvent) begin
      apicPend_next = 1'b1;
      apicVec_next = apicVector;
    end
  end

  // ----------------------------------------------------------------
  // Flags, nonmaskable block and shadow
  // ----------------------------------------------------------------
  assign privOk = privAllows(current_privilege_level, io_privilege_threshold);
  assign retFaults = v86Mode & (io_privilege_threshold < `CIG_IO_PRIVILEGE_THRESHOLD_MAX);

  // Applies retired instructions first, then the gate effect of a dispatch.
  always @* begin
    flags_next = flags_reg;
    nmiBlocked_next = nmiBlocked;
    gpFault_next = 1'b0;
    shadow_next = shadow_reg;
    if (retireValid) begin
      shadow_next = (retireOp == `CIG_OP_SS_LOAD);
      case (retireOp)
        `CIG_OP_SET_IF: begin
          if (privOk) begin
            flags_next[`CIG_FLAG_IF] = 1'b1;
          end else begin
            gpFault_next = 1'b1;
          end
        end
        `CIG_OP_CLR_IF: begin
          if (privOk) begin
            flags_next[`CIG_FLAG_IF] = 1'b0;
          end else begin
            gpFault_next = 1'b1;
          end
        end
        `CIG_OP_POP_FLAGS: begin
          flags_next = flagImage;
        end
        `CIG_OP_TASK_SW: begin
          flags_next = flagImage;
        end
        `CIG_OP_RET_INT: begin
          // The block is lifted before the fault handler is entered.
          nmiBlocked_next = 1'b0;
          if (retFaults) begin
            gpFault_next = 1'b1;
          end else begin
            flags_next = flagImage;
          end
        end
        default: begin
          flags_next = flags_reg;
        end
      endcase
    end
    if (kind_next == `CIG_KIND_NMI) begin
      nmiBlocked_next = 1'b1;
    end
    if (taking && !gateIsTrap) begin
      flags_next[`CIG_FLAG_IF] = 1'b0;
    end
  end

  // State registers; reset clears the flag, the block and the shadow.
  always @(posedge clk) begin
    if (rst) begin
      flags_reg <= `CIG_FLAGS_RESET;
      nmiBlocked <= 1'b0;
      shadow_reg <= 1'b0;
      nmiPend_reg <= 1'b0;
      apicPend_reg <= 1'b0;
      apicVec_reg <= 8'h00;
      ifFlag <= 1'b0;
      resumeFlag <= 1'b0;
      apicReady <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      nmiBlocked <= nmiBlocked_next;
      shadow_reg <= shadow_next;
      nmiPend_reg <= nmiPend_next;
      apicPend_reg <= apicPend_next;
      apicVec_reg <= apicVec_next;
      ifFlag <= flags_next[`CIG_FLAG_IF];
      resumeFlag <= flags_next[`CIG_FLAG_RF];
      apicReady <= ~apicPend_next & apicEnable;
    end
  end

  // ----------------------------------------------------------------
  // Dispatch and push outputs
  // ----------------------------------------------------------------
  // Dispatch outputs are one-cycle pulses after the boundary cycle.
  always @(posedge clk) begin
    if (rst) begin
      dispatchValid <= 1'b0;
      dispatchVector <= 8'h00;
      dispatchKind <= `CIG_KIND_NONE;
      pushErrorCode <= 1'b0;
      intrAck <= 1'b0;
      excTaken <= 1'b0;
      gpFault <= 1'b0;
      pushValid <= 1'b0;
      pushData <= 32'h00000000;
      last_reg <= 11'h000;
    end else begin
      dispatchValid <= taking;
      dispatchVector <= vector_next;
      dispatchKind <= kind_next;
      pushErrorCode <= errCode_next;
      intrAck <= (kind_next == `CIG_KIND_PIN);
      excTaken <= (kind_next == `CIG_KIND_EXC);
      gpFault <= gpFault_next;
      pushValid <= retireValid & (retireOp == `CIG_OP_PUSH_FLAGS);
      if (retireValid && retireOp == `CIG_OP_PUSH_FLAGS) begin
        pushData <= flags_reg;
      end
      if (taking) begin
        last_reg <= {kind_next, vector_next};
      end
    end
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  assign statusWord = {26'h0000000, apicPend_reg, nmiPend_reg, shadow_reg, nmiBlocked,
                       flags_reg[`CIG_FLAG_RF], flags_reg[`CIG_FLAG_IF]};

  cig_apb_port uApb (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .statusWord(statusWord),
    .lastWord({21'h000000, last_reg}),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctrlReg(ctrlReg)
  );
endmodule

// File: cig_regs.vh
// Constants for the core interrupt gating block.
// What this block does
// - Accept nonmaskable from pin or bus message
// - Nonmaskable dispatches to vector two at the next boundary, below a debug trap
// - Interrupt flag never masks nonmaskable requests
// - Pin vector two stays an ordinary interrupt
// - Block further nonmaskable until interrupt return
// - Faulting interrupt return still lifts nonmaskable block
// - Clear interrupt flag blocks pin and controller
// - Interrupt flag ignores core generated exceptions
// - Reset clears the interrupt flag
// - Accept pin and controller vectors, dispatch them
// - Pin interrupts never push an error code
// - Flag set/clear needs privilege, else fault
// - Flag loads reload whole flags register
// - Push flags writes every flag bit out
// - Interrupt gate clears flag, trap gate keeps
// - Resume flag suppresses instruction breakpoint exception
// - Stack segment load shadows interrupts, debug
// - Lower priority interrupts stay pending, not dropped
`ifndef CIG_REGS_VH
`define CIG_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CIG_ADDR_STATUS 12'h000
`define CIG_ADDR_LAST 12'h004
`define CIG_ADDR_CTRL 12'h008
`define CIG_CTRL_RESET 32'h00000001
`define CIG_CTRL_LOCAL_INTERRUPT_CONTROLLER_EN 0

// ----------------------------------------------------------------
// Flags register layout
// ----------------------------------------------------------------
`define CIG_FLAGS_RESET 32'h00000002
`define CIG_FLAG_IF 9
`define CIG_FLAG_RF 16

// ----------------------------------------------------------------
// Retired instruction codes
// ----------------------------------------------------------------
`define CIG_OP_NONE 4'h0
`define CIG_OP_SET_IF 4'h1
`define CIG_OP_CLR_IF 4'h2
`define CIG_OP_POP_FLAGS 4'h3
`define CIG_OP_PUSH_FLAGS 4'h4
`define CIG_OP_RET_INT 4'h5
`define CIG_OP_TASK_SW 4'h6
`define CIG_OP_SS_LOAD 4'h7

// ----------------------------------------------------------------
// Vectors, privilege and dispatch kinds
// ----------------------------------------------------------------
`define CIG_VEC_NMI 8'h02
`define CIG_VEC_DEBUG 8'h01
`define CIG_IO_PRIVILEGE_THRESHOLD_MAX 2'h3
`define CIG_KIND_NONE 3'h0
`define CIG_KIND_NMI 3'h1
`define CIG_KIND_PIN 3'h2
`define CIG_KIND_LOCAL_INTERRUPT_CONTROLLER 3'h3
`define CIG_KIND_EXC 3'h4
`define CIG_KIND_DEBUG 3'h5

`endif

// File: cig_sync.v
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/100ps
module cig_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] async,
  output reg [WIDTH-1:0] synced
);
  reg [WIDTH-1:0] stage1_reg;

  // The first stage feeds only the second stage.
  always @(posedge clk) begin
    if (rst) begin
      stage1_reg <= {WIDTH{1'b0}};
      synced <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async;
      synced <= stage1_reg;
    end
  end
endmodule

// File: cig_apb_port.v
// APB slave holding the control register and serving status reads.
`timescale 1ns/100ps
`include "cig_regs.vh"
module cig_apb_port (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] statusWord,
  input wire [31:0] lastWord,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [31:0] ctrlReg
);
  wire setupPhase;
  wire mapped;
  wire doWrite;

  // A setup cycle is answered in the first access cycle.
  assign setupPhase = psel & ~penable;
  assign mapped = (paddr == `CIG_ADDR_STATUS) || (paddr == `CIG_ADDR_LAST) ||
                  (paddr == `CIG_ADDR_CTRL);
  assign doWrite = psel & penable & pready & pwrite & ~pslverr;

  // Ready, error and read data are registered during the setup cycle.
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~mapped;
      if (setupPhase && !pwrite) begin
        case (paddr)
          `CIG_ADDR_STATUS: prdata <= statusWord;
          `CIG_ADDR_LAST: prdata <= lastWord;
          `CIG_ADDR_CTRL: prdata <= ctrlReg;
          default: prdata <= 32'h00000000;
        endcase
      end else if (setupPhase) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // The control register takes its value at the completing access edge.
  always @(posedge clk) begin
    if (rst) begin
      ctrlReg <= `CIG_CTRL_RESET;
    end else if (doWrite && paddr == `CIG_ADDR_CTRL) begin
      ctrlReg <= {31'h00000000, pwdata[`CIG_CTRL_LOCAL_INTERRUPT_CONTROLLER_EN]};
    end
  end
endmodule

// File: cig_checker.sv
// Port assertions for the core interrupt gating block.
`timescale 1ns/100ps
module cig_checker (
  input wire clk,
  input wire rst,
  input wire boundary,
  input wire retireValid,
  input wire [3:0] retireOp,
  input wire [1:0] current_privilege_level,
  input wire [1:0] io_privilege_threshold,
  input wire gateIsTrap,
  input wire bpMatch,
  input wire stepTrap,
  input wire dispatchValid,
  input wire [7:0] dispatchVector,
  input wire [2:0] dispatchKind,
  input wire pushErrorCode,
  input wire intrAck,
  input wire gpFault,
  input wire ifFlag,
  input wire resumeFlag,
  input wire nmiBlocked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Dispatch classes, and boundaries with no retire beside them.
  wire nmiDisp = dispatchValid && dispatchKind == 3'h1;
  wire maskDisp = dispatchValid && (dispatchKind == 3'h2 || dispatchKind == 3'h3);
  wire quiet = boundary && !retireValid;
  sequence ssLoad;
    retireValid && retireOp == 4'h7;
  endsequence
  sequence nextBnd;
    !retireValid ##1 quiet;
  endsequence
  nmi_vector_a: assert property (nmiDisp |-> dispatchVector == 8'h02 && nmiBlocked)
    else $error("nmi dispatch wrong");
  nmi_nest_a: assert property (quiet && nmiBlocked |=> !nmiDisp)
    else $error("nested nmi taken");
  ret_unblock_a: assert property (retireValid && retireOp == 4'h5 && !boundary |=> !nmiBlocked)
    else $error("nmi block kept");
  if_mask_a: assert property (quiet && !ifFlag |=> !maskDisp)
    else $error("masked request taken");
  int_gate_a: assert property (dispatchValid && !$past(gateIsTrap) |-> !ifFlag)
    else $error("gate left flag set");
  trap_gate_a: assert property (quiet && gateIsTrap && ifFlag |=> ifFlag)
    else $error("trap gate cleared flag");
  reset_clear_a: assert property ($fell(rst) |-> !ifFlag && !nmiBlocked && !dispatchValid)
    else $error("state after reset");
  priv_fault_a: assert property (retireValid && (retireOp == 4'h1 || retireOp == 4'h2)
    |=> gpFault == ($past(current_privilege_level) > $past(io_privilege_threshold)))
    else $error("privilege fault wrong");
  rf_mask_a: assert property (quiet && bpMatch && resumeFlag && !stepTrap
    |=> !(dispatchValid && dispatchKind == 3'h5))
    else $error("breakpoint not masked");
  pin_plain_a: assert property (dispatchValid && dispatchKind == 3'h2
    |-> intrAck && !pushErrorCode && (!nmiBlocked || $past(nmiBlocked)))
    else $error("pin dispatch wrong");
  shadow_a: assert property (ssLoad ##1 nextBnd |=> !dispatchValid || dispatchKind == 3'h4)
    else $error("shadow broken");
endmodule
bind cig_core cig_checker cig_checker_i (.*);

// File: cig_src_model.sv
// Model of the interrupt sources and local controller facing the core.
`timescale 1ns/100ps
module cig_src_model (
  input wire clk,
  input wire intrAck,
  input wire apicReady,
  output reg nmiPin,
  output reg intrPin,
  output reg [7:0] intrVector,
  output reg busNmiMsg,
  output reg apicValid,
  output reg apicNmi,
  output reg [7:0] apicVector
);
  integer n;
  // All lines idle at time zero.
  initial begin
    {nmiPin, intrPin, busNmiMsg, apicValid, apicNmi} = 5'h00;
    {intrVector, apicVector} = 16'h0000;
  end
  // The pin drops on acknowledge and its vector then goes stale.
  always @(posedge clk) begin
    if (intrAck) begin
      intrPin <= 1'b0;
      intrVector <= ~intrVector;
    end
  end
  // Pin pulse long enough to pass the synchroniser.
  task nmi;
    begin
      @(posedge clk) nmiPin <= 1'b1;
      repeat (4) @(posedge clk);
      nmiPin <= 1'b0;
    end
  endtask
  // Maskable pin request, held until acknowledged.
  task external_maskable_pin(input [7:0] v);
    begin
      @(posedge clk) intrPin <= 1'b1;
      intrVector <= v;
      repeat (3) @(posedge clk);
    end
  endtask
  // One message; a maskable one waits up to 20 cycles while the controller is not ready.
  task msg(input bus, input isNmi, input [7:0] v);
    begin
      for (n = 0; n < 20 && !isNmi && apicReady !== 1'b1; n = n + 1) @(posedge clk);
      @(posedge clk) busNmiMsg <= bus;
      apicValid <= !bus;
      apicNmi <= isNmi;
      apicVector <= v;
      @(posedge clk) busNmiMsg <= 1'b0;
      apicValid <= 1'b0;
      apicVector <= ~v;
    end
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the core interrupt gating block.
`timescale 1ns/100ps
`include "cig_regs.vh"
module testbench;
  logic clk, rst, boundary, retireValid, v86Mode, gateIsTrap, excValid;
  logic excHasErrCode, bpMatch, stepTrap, psel, penable, pwrite, err;
  logic [3:0] retireOp;
  logic [1:0] current_privilege_level, io_privilege_threshold;
  logic [7:0] excVector;
  logic [11:0] paddr;
  logic [31:0] flagImage, pwdata, rd;
  wire nmiPin, intrPin, busNmiMsg, apicValid, apicNmi, intrAck, apicReady, pready;
  wire pslverr, dispatchValid, pushErrorCode, excTaken, gpFault, pushValid;
  wire ifFlag, resumeFlag, nmiBlocked;
  wire [2:0] dispatchKind;
  wire [7:0] intrVector, apicVector, dispatchVector;
  wire [31:0] prdata, pushData;
  integer errors, total_checks, i, k;
  typedef struct packed {
    logic [3:0] sel;
    logic [7:0] ev;
    logic [2:0] kd;
    logic [7:0] vec;
  } cig_row_t;
  // Exception and debug sources beside the dispatch they give.
  cig_row_t rows [6] = '{'{4'hC, 8'h0D, 3'h4, 8'h0D}, '{4'h8, 8'h00, 3'h4, 8'h00},
    '{4'h2, 8'h00, 3'h5, 8'h01}, '{4'h1, 8'h00, 3'h5, 8'h01},
    '{4'h9, 8'h06, 3'h5, 8'h01}, '{4'hA, 8'h06, 3'h5, 8'h01}};
  logic [7:0] pv [4] = '{8'h00, 8'h02, 8'h0E, 8'h20};
  cig_core cig_core_i (.*);
  cig_src_model cig_src_model_i (.*);
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input [32:0] seen, input [32:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      if (errors == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // One APB transfer; the wait for pready is bounded.
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk) psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      for (k = 0; k < 9 && pready !== 1'b1; k = k + 1) @(posedge clk);
      if (pready !== 1'b1) begin
        errors = errors + 1;
        finish_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // One boundary pulse, then the dispatch it gives is checked.
  task bnd(input [2:0] kd, input [7:0] vec);
    begin
      @(posedge clk) boundary <= 1'b1;
      @(posedge clk) boundary <= 1'b0;
      #1 chk(dispatchValid, kd != 3'h0);
      if (kd != 3'h0) chk({dispatchKind, dispatchVector}, {kd, vec});
    end
  endtask
  // One retired instruction; its results show one cycle later.
  task ret(input [3:0] op);
    begin
      @(posedge clk) retireValid <= 1'b1;
      retireOp <= op;
      @(posedge clk) retireValid <= 1'b0;
      #1;
    end
  endtask
  // Main sequence.
  initial begin
    rst = 1'b1;
    {boundary, retireValid, v86Mode, gateIsTrap, excValid, excHasErrCode} = 6'h00;
    {bpMatch, stepTrap, psel, penable, pwrite} = 5'h00;
    {current_privilege_level, io_privilege_threshold, retireOp, excVector, paddr} = 28'h0000000;
    pwdata = 32'h00000000;
    flagImage = `CIG_FLAGS_RESET;
    errors = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 chk({ifFlag, nmiBlocked}, 2'h0);
    apb(1'b0, `CIG_ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, `CIG_ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    chk(err, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clk) {excValid, excHasErrCode, bpMatch, stepTrap} <= rows[i].sel;
      excVector <= rows[i].ev;
      bnd(rows[i].kd, rows[i].vec);
      chk({pushErrorCode, excTaken}, {rows[i].sel == 4'hC, rows[i].kd == 3'h4});
      @(posedge clk) {excValid, excHasErrCode, bpMatch, stepTrap} <= 4'h0;
    end
    @(posedge clk) current_privilege_level <= 2'h3;
    ret(`CIG_OP_SET_IF);
    chk({gpFault, ifFlag}, 2'h2);
    @(posedge clk) io_privilege_threshold <= 2'h3;
    ret(`CIG_OP_SET_IF);
    chk({gpFault, ifFlag}, 2'h1);
    @(posedge clk) gateIsTrap <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      cig_src_model_i.external_maskable_pin(pv[i]);
      bnd(3'h2, pv[i]);
      chk({pushErrorCode, nmiBlocked, ifFlag}, 3'h1);
      repeat (3) @(posedge clk);
    end
    ret(`CIG_OP_CLR_IF);
    @(posedge clk) gateIsTrap <= 1'b0;
    cig_src_model_i.nmi;
    bnd(3'h1, 8'h02);
    chk(nmiBlocked, 1'b1);
    cig_src_model_i.msg(1'b1, 1'b1, 8'h00);
    bnd(3'h0, 8'h00);
    ret(`CIG_OP_RET_INT);
    chk(nmiBlocked, 1'b0);
    bnd(3'h1, 8'h02);
    @(posedge clk) v86Mode <= 1'b1;
    io_privilege_threshold <= 2'h0;
    flagImage <= 32'h00000202;
    ret(`CIG_OP_RET_INT);
    chk({gpFault, nmiBlocked, ifFlag}, 3'h4);
    cig_src_model_i.msg(1'b0, 1'b1, 8'h00);
    bnd(3'h1, 8'h02);
    @(posedge clk) v86Mode <= 1'b0;
    ret(`CIG_OP_RET_INT);
    chk({gpFault, nmiBlocked, ifFlag}, 3'h1);
    @(posedge clk) gateIsTrap <= 1'b1;
    cig_src_model_i.msg(1'b0, 1'b0, 8'h10);
    cig_src_model_i.nmi;
    bnd(3'h1, 8'h02);
    bnd(3'h3, 8'h10);
    ret(`CIG_OP_RET_INT);
    cig_src_model_i.msg(1'b0, 1'b0, 8'h20);
    bnd(3'h3, 8'h20);
    @(posedge clk) flagImage <= 32'h00010202;
    ret(`CIG_OP_POP_FLAGS);
    chk({resumeFlag, ifFlag}, 2'h3);
    @(posedge clk) bpMatch <= 1'b1;
    bnd(3'h0, 8'h00);
    @(posedge clk) bpMatch <= 1'b0;
    ret(`CIG_OP_PUSH_FLAGS);
    chk({pushValid, pushData}, {1'b1, 32'h00010202});
    cig_src_model_i.external_maskable_pin(8'h1F);
    ret(`CIG_OP_SS_LOAD);
    bnd(3'h0, 8'h00);
    @(posedge clk) excValid <= 1'b1;
    excVector <= 8'h0D;
    bnd(3'h4, 8'h0D);
    @(posedge clk) excValid <= 1'b0;
    gateIsTrap <= 1'b0;
    ret(`CIG_OP_NONE);
    bnd(3'h2, 8'h1F);
    chk(ifFlag, 1'b0);
    apb(1'b0, `CIG_ADDR_LAST, 32'h0);
    chk(rd, 32'h0000021F);
    apb(1'b1, `CIG_ADDR_CTRL, 32'h0);
    @(posedge clk) #1 chk(apicReady, 1'b0);
    ret(`CIG_OP_POP_FLAGS);
    cig_src_model_i.msg(1'b0, 1'b0, 8'h11);
    bnd(3'h0, 8'h00);
    apb(1'b0, `CIG_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    cig_src_model_i.nmi;
    bnd(3'h1, 8'h02);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk({ifFlag, resumeFlag, nmiBlocked}, 3'h0);
    apb(1'b0, `CIG_ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    chk(apicReady, 1'b1);
    finish_test;
  end
endmodule
